// [hw/umls_pkg.sv]
package umls_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_THR = 8'h00;
  localparam logic [7:0] ADDR_IER = 8'h04;
  localparam logic [7:0] ADDR_MCR = 8'h10;
  localparam logic [7:0] ADDR_LSR = 8'h14;
  localparam logic [7:0] ADDR_MSR = 8'h18;
  localparam logic [7:0] ADDR_EFR = 8'h20;
  localparam logic [7:0] ADDR_FEATURE_CONTROL_REG = 8'h24;
  localparam logic [7:0] ADDR_TXCTL = 8'h28;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MC_PRESC = 7;
  localparam int MC_IRDA = 6;
  localparam int MC_XANY = 5;
  localparam int MC_LOOP = 4;
  localparam int MC_SIMM = 3;
  localparam int MC_SEL = 2;
  localparam int MC_RTS = 1;
  localparam int MC_DTR = 0;
  localparam int EF_ENH = 4;
  localparam int EF_AUTO = 6;
  localparam int IE_LINE = 2;
  localparam int IE_MODEM = 3;
  localparam int FC_RXINV = 4;
  localparam int TC_DIS = 0;
  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] MCR_RST = 8'h00;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [1:0] PRESC_LAST = 2'h3;
  localparam logic [3:0] IR_PULSE = 4'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    SI_IDLE = 3'b001,
    SI_WAIT = 3'b010,
    SI_SEND = 3'b100
  } umls_si_type;
endpackage : umls_pkg

// [hw/umls_top.sv]
`timescale 1ns/10ps
// Functional notes
// - Prescaler bit divides baud clock by four; writable only with enhanced enable.
// - Infrared enable loads from strap pin at reset release; software may overwrite only with enhanced enable.
// - Infrared mode routes serial through encoder/decoder; idle output low; optional invert.
// - Xon-any makes any received character resume transmission; off by default.
// - Loopback bit selects internal local loopback; normal mode after reset.
// - Send-immediate sends next holding write ahead of the queue, then self-clears.
// - Send-immediate waits for transmitter enabled; pending Xon/Xoff go first.
// - Loopback mirrors control bits 3,2,0,1 into status bits 7,6,5,4.
// - Auto flow uses RTS/CTS when select is 0, DTR/DSR when 1.
// - RTS and DTR outputs are the inverted control bits unless loopback (forced high) or auto flow owns them.
// - Line-status interrupt fires while an errored character is held, if enabled.
// - FIFO data error flag set while any entry has parity, framing or break.
// - Transmitter empty only when holding FIFO and shift register are both empty.
// - Transmit FIFO empty follows the FIFO or holding register emptiness.
// - Break flagged on a low frame; one break character loaded; held until idle.
// - Framing and parity errors belong to the character at the FIFO top.
// - New character with FIFO full sets overrun and is not pushed.
// - Data ready while at least one received character is held.
// - Normal mode shows complemented carrier, ring, DSR and CTS inputs.
// - Auto CTS/DSR flow stops after current character while the input is high.
// - Delta carrier flag on any change; modem interrupt when enabled.
// - Delta ring on ring end only; delta DSR and CTS on any change.
module umls_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic infrared_strap_pin,
  input wire logic rx_pin,
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic cd_n,
  input wire logic ri_n,
  input wire logic tx_serial,
  input wire logic baud16_tick,
  input wire logic rx_char_done,
  input wire logic rx_fifo_full,
  input wire logic rx_not_empty,
  input wire logic rx_top_pe,
  input wire logic rx_top_fe,
  input wire logic rx_top_bi,
  input wire logic rx_fifo_err,
  input wire logic rx_break_det,
  input wire logic rx_flow_stop,
  input wire logic tx_fifo_empty,
  input wire logic tsr_empty,
  input wire logic sw_flow_pending,
  input wire logic imm_taken,
  output logic baud_en,
  output logic tx_pin,
  output logic rx_to_core,
  output logic rts_n,
  output logic dtr_n,
  output logic tx_stop,
  output logic xon_resume,
  output logic rx_push,
  output logic brk_load,
  output logic thr_wr,
  output logic [7:0] thr_data,
  output logic imm_valid,
  output logic [7:0] imm_data,
  output logic line_irq,
  output logic modem_irq
);
  import umls_pkg::*;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic aw_have_q, w_have_q, bvalid_q, arready_q, rvalid_q;
  logic [7:0] awaddr_q, wdata_q;
  logic wstrb0_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic wr_go, rd_go, wr_lane;
  logic [7:0] mcr_q, ier_q, efr_q, feature_control_reg_q, txctl_q, lsr_c;
  logic [3:0] st_q, st_d, dlt_q;
  umls_si_type si_q;
  logic loop, armed;

  function automatic logic known(input logic [7:0] a);
    known = (a == ADDR_THR) || (a == ADDR_IER) || (a == ADDR_MCR) || (a == ADDR_LSR)
         || (a == ADDR_MSR) || (a == ADDR_EFR) || (a == ADDR_FEATURE_CONTROL_REG) || (a == ADDR_TXCTL);
  endfunction : known

  assign wr_go = aw_have_q && w_have_q && !bvalid_q;
  assign wr_lane = wr_go && wstrb0_q;
  assign rd_go = s_axi_arvalid && arready_q;
  assign loop = mcr_q[MC_LOOP];
  assign armed = mcr_q[MC_SIMM] && !loop;

  // Address and data are latched independently, so either may come first.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= REG_RST;
      wdata_q <= REG_RST;
      wstrb0_q <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && !aw_have_q)
      begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      else if (wr_go)
        aw_have_q <= 1'b0;
      if (s_axi_wvalid && !w_have_q)
      begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
      end
      else if (wr_go)
        w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= known(awaddr_q) && awaddr_q != ADDR_LSR && awaddr_q != ADDR_MSR
               ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_q <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end
    else
    begin
      arready_q <= !rvalid_q && !rd_go && !arready_q;
      if (rd_go)
      begin
        rvalid_q <= 1'b1;
        rresp_q <= known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        unique case (s_axi_araddr)
          ADDR_IER: rdata_q <= {24'h00_0000, ier_q};
          ADDR_MCR: rdata_q <= {24'h00_0000, mcr_q};
          ADDR_LSR: rdata_q <= {24'h00_0000, lsr_c};
          ADDR_MSR: rdata_q <= {24'h00_0000, st_q, dlt_q};
          ADDR_EFR: rdata_q <= {24'h00_0000, efr_q};
          ADDR_FEATURE_CONTROL_REG: rdata_q <= {24'h00_0000, feature_control_reg_q};
          ADDR_TXCTL: rdata_q <= {24'h00_0000, txctl_q};
          default: rdata_q <= 32'h0000_0000;
        endcase
      end
      else if (s_axi_rready)
        rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic strap_load_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ier_q <= REG_RST;
      efr_q <= REG_RST;
      feature_control_reg_q <= REG_RST;
      txctl_q <= REG_RST;
    end
    else if (wr_lane)
    begin
      if (awaddr_q == ADDR_IER)
        ier_q <= wdata_q;
      if (awaddr_q == ADDR_EFR)
        efr_q <= wdata_q;
      if (awaddr_q == ADDR_FEATURE_CONTROL_REG)
        feature_control_reg_q <= wdata_q;
      if (awaddr_q == ADDR_TXCTL)
        txctl_q <= wdata_q;
    end
  end

  // The strap is caught one edge after release, since reset loads constants only.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      strap_load_q <= 1'b1;
      mcr_q <= MCR_RST;
    end
    else
    begin
      strap_load_q <= 1'b0;
      if (strap_load_q)
        mcr_q[MC_IRDA] <= infrared_strap_pin;
      if (wr_lane && awaddr_q == ADDR_MCR)
      begin
        if (efr_q[EF_ENH])
          mcr_q[7:5] <= wdata_q[7:5];
        mcr_q[4:0] <= wdata_q[4:0];
      end
      else if (wr_lane && awaddr_q == ADDR_THR && armed)
        mcr_q[MC_SIMM] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Send immediate
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      si_q <= SI_IDLE;
      imm_data <= REG_RST;
      imm_valid <= 1'b0;
      thr_wr <= 1'b0;
      thr_data <= REG_RST;
    end
    else
    begin
      thr_wr <= 1'b0;
      unique case (si_q)
        SI_IDLE:
        begin
          if (wr_lane && awaddr_q == ADDR_THR && armed)
          begin
            si_q <= SI_WAIT;
            imm_data <= wdata_q;
          end
          else if (wr_lane && awaddr_q == ADDR_THR)
          begin
            thr_wr <= 1'b1;
            thr_data <= wdata_q;
          end
        end
        SI_WAIT:
        begin
          // wait for enable and flow characters
          if (!txctl_q[TC_DIS] && !sw_flow_pending)
          begin
            si_q <= SI_SEND;
            imm_valid <= 1'b1;
          end
        end
        SI_SEND:
        begin
          if (imm_taken)
          begin
            si_q <= SI_IDLE;
            imm_valid <= 1'b0;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Clock prescaler and serial routing
  // ----------------------------------------------------------------
  logic [1:0] pre_q;
  logic [3:0] ir_cnt_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pre_q <= 2'h0;
      baud_en <= 1'b0;
    end
    else
    begin
      pre_q <= pre_q + 2'h1;
      baud_en <= mcr_q[MC_PRESC] ? (pre_q == PRESC_LAST) : 1'b1;
    end
  end

  // The encoder phase runs free on the 16x tick; the pulse may start up to 13 ticks late.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ir_cnt_q <= 4'h0;
    else if (baud16_tick)
      ir_cnt_q <= ir_cnt_q + 4'h1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_pin <= 1'b1;
      rx_to_core <= 1'b1;
    end
    else if (loop)
    begin
      tx_pin <= !mcr_q[MC_IRDA];
      rx_to_core <= tx_serial;
    end
    else if (mcr_q[MC_IRDA])
    begin
      tx_pin <= !tx_serial && (ir_cnt_q < IR_PULSE);
      rx_to_core <= !(rx_pin ^ feature_control_reg_q[FC_RXINV]);
    end
    else
    begin
      tx_pin <= tx_serial;
      rx_to_core <= rx_pin;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      xon_resume <= 1'b0;
    else
      xon_resume <= rx_char_done && mcr_q[MC_XANY];
  end

  // ----------------------------------------------------------------
  // Modem outputs and flow control
  // ----------------------------------------------------------------
  logic own_rts, own_dtr;
  assign own_rts = efr_q[EF_AUTO] && !mcr_q[MC_SEL];
  assign own_dtr = efr_q[EF_AUTO] && mcr_q[MC_SEL];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rts_n <= 1'b1;
      dtr_n <= 1'b1;
      tx_stop <= 1'b0;
    end
    else
    begin
      rts_n <= loop || (own_rts ? rx_flow_stop : !mcr_q[MC_RTS]);
      dtr_n <= loop || (own_dtr ? rx_flow_stop : !mcr_q[MC_DTR]);
      tx_stop <= efr_q[EF_AUTO] && !loop && (mcr_q[MC_SEL] ? dsr_n : cts_n);
    end
  end

  // ----------------------------------------------------------------
  // Line status
  // ----------------------------------------------------------------
  logic ovr_q, brk_hold_q, ovr_ev, lsr_rd;
  assign ovr_ev = rx_char_done && rx_fifo_full;
  assign lsr_rd = rd_go && s_axi_araddr == ADDR_LSR;
  // fifo error, tx empty, holding empty, ready
  assign lsr_c = {rx_fifo_err, tx_fifo_empty && tsr_empty, tx_fifo_empty,
                  rx_top_bi || brk_hold_q, rx_top_fe, rx_top_pe, ovr_q, rx_not_empty};

  // An overrun that lands on the clearing read stays set.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ovr_q <= 1'b0;
      rx_push <= 1'b0;
    end
    else
    begin
      ovr_q <= ovr_ev || (ovr_q && !lsr_rd);
      rx_push <= rx_char_done && !rx_fifo_full;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      brk_hold_q <= 1'b0;
      brk_load <= 1'b0;
    end
    else
    begin
      brk_load <= rx_break_det && !brk_hold_q;
      brk_hold_q <= rx_break_det || (brk_hold_q && !rx_to_core);
    end
  end

  // ----------------------------------------------------------------
  // Modem status and interrupts
  // ----------------------------------------------------------------
  logic msr_rd;
  assign msr_rd = rd_go && s_axi_araddr == ADDR_MSR;
  assign st_d = loop ? {mcr_q[MC_SIMM], mcr_q[MC_SEL], mcr_q[MC_DTR], mcr_q[MC_RTS]}
                     : {!cd_n, !ri_n, !dsr_n, !cts_n};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q <= 4'h0;
      dlt_q <= 4'h0;
    end
    else
    begin
      st_q <= st_d;
      dlt_q[3] <= (st_d[3] ^ st_q[3]) || (dlt_q[3] && !msr_rd);
      dlt_q[2] <= (st_q[2] && !st_d[2]) || (dlt_q[2] && !msr_rd);
      dlt_q[1:0] <= (st_d[1:0] ^ st_q[1:0]) | (dlt_q[1:0] & {2{!msr_rd}});
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      line_irq <= 1'b0;
      modem_irq <= 1'b0;
    end
    else
    begin
      line_irq <= ier_q[IE_LINE] && (rx_fifo_err || rx_top_pe || rx_top_fe
                                     || rx_top_bi || ovr_q);
      modem_irq <= ier_q[IE_MODEM] && (dlt_q != 4'h0);
    end
  end

  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready = !w_have_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_presc;
    mcr_q[MC_PRESC] && $past(mcr_q[MC_PRESC]) && baud_en |=> !baud_en;
  endproperty
  a_presc: assert property (p_presc) else $error("prescaler pulse too close");
  property p_strap;
    $rose(aresetn) |=> mcr_q[MC_IRDA] == $past(infrared_strap_pin);
  endproperty
  a_strap: assert property (p_strap) else $error("strap not loaded");
  property p_ir_idle;
    mcr_q[MC_IRDA] && !loop && tx_serial |=> !tx_pin;
  endproperty
  a_ir_idle: assert property (p_ir_idle) else $error("infrared idle not low");
  property p_xany;
    rx_char_done && mcr_q[MC_XANY] |=> xon_resume;
  endproperty
  a_xany: assert property (p_xany) else $error("xon any missed");
  property p_simm;
    wr_lane && awaddr_q == ADDR_THR && armed && si_q == SI_IDLE
      |=> !mcr_q[MC_SIMM] && si_q == SI_WAIT && !thr_wr;
  endproperty
  a_simm: assert property (p_simm) else $error("send immediate not taken");
  property p_txdis;
    $rose(imm_valid) |-> $past(!txctl_q[TC_DIS] && !sw_flow_pending);
  endproperty
  a_txdis: assert property (p_txdis) else $error("sent while disabled");
  property p_mirror;
    loop |=> st_q == $past({mcr_q[MC_SIMM], mcr_q[MC_SEL], mcr_q[MC_DTR], mcr_q[MC_RTS]});
  endproperty
  a_mirror: assert property (p_mirror) else $error("loopback mirror wrong");
  property p_rts;
    !loop && !own_rts |=> rts_n == !$past(mcr_q[MC_RTS]);
  endproperty
  a_rts: assert property (p_rts) else $error("rts level wrong");
  property p_ovr;
    ovr_ev |=> ovr_q && !rx_push;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not flagged");
  property p_cts;
    efr_q[EF_AUTO] && !loop && !mcr_q[MC_SEL] && cts_n |=> tx_stop;
  endproperty
  a_cts: assert property (p_cts) else $error("cts stop missed");
  property p_ring;
    $fell(st_q[2]) |-> dlt_q[2];
  endproperty
  a_ring: assert property (p_ring) else $error("ring delta missed");
  property p_msr_clr;
    msr_rd && st_d == st_q |=> dlt_q == 4'h0;
  endproperty
  a_msr_clr: assert property (p_msr_clr) else $error("deltas not cleared");
endmodule : umls_top

// [dv/umls_modem_model.sv]
`timescale 1ns/10ps
// ------------------------------------------------------------------
// Modem and serial line model
// ------------------------------------------------------------------
module umls_modem_model (
  input wire logic aclk,
  input wire logic [4:0] want,
  input wire logic [3:0] lag,
  output logic rx_pin,
  output logic cts_n,
  output logic dsr_n,
  output logic cd_n,
  output logic ri_n
);
  logic [3:0] cnt;
  logic [4:0] cur;
  initial cur = 5'h1f;
  initial cnt = 4'h0;
  assign {rx_pin, cts_n, dsr_n, cd_n, ri_n} = cur;
  // A change waits lag cycles, so a slow modem is covered as well as a prompt one.
  always @(posedge aclk)
  begin
    if (want == cur)
      cnt <= 4'h0;
    else if (cnt >= lag)
      cur <= want;
    else
      cnt <= cnt + 4'h1;
  end
endmodule : umls_modem_model

// [dv/uart_modem_line_status_tb_top.sv]
`timescale 1ns/10ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_count++; $display("wrong value at %0t: got %h want %h", $time, a, e); end end
module uart_modem_line_status_tb_top;
  import umls_pkg::*;
  // ------------------------------------------------------------------
  // Signals and bus tasks
  // ------------------------------------------------------------------
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb, lag;
  logic infrared_strap_pin, tx_serial, baud16_tick, rx_char_done, rx_fifo_full, rx_not_empty;
  logic rx_top_pe, rx_top_fe, rx_top_bi, rx_fifo_err, rx_break_det, rx_flow_stop;
  logic tx_fifo_empty, tsr_empty, sw_flow_pending, imm_taken;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic rx_pin, cts_n, dsr_n, cd_n, ri_n, baud_en, tx_pin, rx_to_core, rts_n, dtr_n;
  wire logic tx_stop, xon_resume, rx_push, brk_load, thr_wr, imm_valid, line_irq, modem_irq;
  wire logic [7:0] thr_data, imm_data;
  logic [4:0] want, p;
  logic [7:0] v, m, rd;
  logic [1:0] rs;
  integer err_count, comparisons, seed, i, cyc, thr_cnt, push_cnt;

  umls_top umls_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .infrared_strap_pin, .rx_pin, .cts_n, .dsr_n, .cd_n, .ri_n,
    .tx_serial, .baud16_tick, .rx_char_done, .rx_fifo_full, .rx_not_empty, .rx_top_pe,
    .rx_top_fe, .rx_top_bi, .rx_fifo_err, .rx_break_det, .rx_flow_stop, .tx_fifo_empty,
    .tsr_empty, .sw_flow_pending, .imm_taken, .baud_en, .tx_pin, .rx_to_core, .rts_n, .dtr_n,
    .tx_stop, .xon_resume, .rx_push, .brk_load, .thr_wr, .thr_data, .imm_valid, .imm_data,
    .line_irq, .modem_irq);
  umls_modem_model umls_modem_model_inst (.aclk, .want, .lag, .rx_pin, .cts_n, .dsr_n, .cd_n,
    .ri_n);

  initial
  begin
    aclk = 1'h0;
    forever #12.5 aclk = ~aclk;
  end

  // The ceiling is far above the several hundred cycles the scenarios need.
  always @(posedge aclk)
  begin
    cyc++;
    baud16_tick <= (cyc[3:0] == 4'h0);
    if (thr_wr === 1'h1) thr_cnt++;
    if (rx_push === 1'h1) push_cnt++;
    if (cyc == 20000)
    begin
      err_count++;
      complete_run();
    end
  end

  task complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run

  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : wr

  task automatic rdr(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata[7:0];
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rdr

  function automatic logic [3:0] msr_hi(logic [7:0] c, logic [4:0] w);
    return c[4] ? {c[3], c[2], c[0], c[1]} : ~{w[1], w[0], w[2], w[3]};
  endfunction : msr_hi

  function automatic logic [3:0] dlt(logic [4:0] o, logic [4:0] n);
    return {o[1] ^ n[1], n[0] & ~o[0], o[2] ^ n[2], o[3] ^ n[3]};
  endfunction : dlt

  function automatic logic [7:0] lsr_exp(logic [7:0] x);
    return {x[6], x[5] & x[4], x[4], x[3], x[2], x[1], 1'h0, x[0]};
  endfunction : lsr_exp

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  initial
  begin
    seed = 32'h2804;
    {err_count, comparisons, cyc, thr_cnt, push_cnt} = '0;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, lag} = '0;
    {rx_char_done, rx_fifo_full, rx_not_empty, rx_top_pe, rx_top_fe, rx_top_bi} = '0;
    {rx_fifo_err, rx_break_det, rx_flow_stop, sw_flow_pending, imm_taken, baud16_tick} = '0;
    {tx_fifo_empty, tsr_empty, tx_serial, infrared_strap_pin} = 4'hf;
    s_axi_wstrb = 4'hf;
    want = 5'h1f;
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    rdr(ADDR_MCR, rd, rs);
    `CHK(rd, 8'h40)
    `CHK(tx_pin, 1'h0)
    wr(ADDR_MCR, 8'h80, rs);
    rdr(ADDR_MCR, rd, rs);
    `CHK(rd, 8'h40)
    v = 8'h00;
    repeat (8) @(posedge aclk) v = v + 8'(baud_en);
    `CHK(v, 8'h08)
    wr(ADDR_EFR, 8'h10, rs);
    wr(ADDR_MCR, 8'h80, rs);
    rdr(ADDR_MCR, rd, rs);
    `CHK(rd, 8'h80)
    `CHK(tx_pin, 1'h1)
    v = 8'h00;
    repeat (8) @(posedge aclk) v = v + 8'(baud_en);
    `CHK(v, 8'h02)
    for (i = 0; i < 12; i++)
    begin
      m = 8'($random(seed)) & 8'h1f;
      if (!m[4]) m[3] = 1'h0;
      want <= 5'h10 | 5'($random(seed));
      wr(ADDR_MCR, m, rs);
      repeat (4) @(posedge aclk);
      rdr(ADDR_MSR, rd, rs);
      `CHK(rd[7:4], msr_hi(m, want))
      `CHK({rts_n, dtr_n}, m[4] ? 2'h3 : ~m[1:0])
    end
    wr(ADDR_MCR, 8'h00, rs);
    wr(ADDR_IER, 8'h08, rs);
    lag <= 4'h3;
    repeat (10) @(posedge aclk);
    rdr(ADDR_MSR, rd, rs);
    p = want;
    for (i = 0; i < 12; i++)
    begin
      want <= 5'h10 | 5'($random(seed));
      repeat (10) @(posedge aclk);
      `CHK(modem_irq, |dlt(p, want))
      rdr(ADDR_MSR, rd, rs);
      `CHK(rd[3:0], dlt(p, want))
      p = want;
    end
    rdr(ADDR_MSR, rd, rs);
    `CHK(rd[3:0], 4'h0)
    wr(ADDR_IER, 8'h04, rs);
    for (i = 0; i < 16; i++)
    begin
      v = (i == 0) ? 8'h7f : 8'($random(seed));
      {rx_fifo_err, tsr_empty, tx_fifo_empty, rx_top_bi, rx_top_fe, rx_top_pe} <= v[6:1];
      rx_not_empty <= v[0];
      repeat (3) @(posedge aclk);
      `CHK(line_irq, |{v[6], v[3:1]})
      rdr(ADDR_LSR, rd, rs);
      `CHK(rd, lsr_exp(v))
    end
    {rx_fifo_err, rx_top_bi, rx_top_fe, rx_top_pe} <= 4'h0;
    rx_fifo_full <= 1'h1;
    rx_char_done <= 1'h1;
    @(posedge aclk) rx_char_done <= 1'h0;
    repeat (3) @(posedge aclk);
    `CHK(push_cnt, 0)
    `CHK(line_irq, 1'h1)
    rdr(ADDR_LSR, rd, rs);
    `CHK(rd[1], 1'h1)
    rdr(ADDR_LSR, rd, rs);
    `CHK(rd[1], 1'h0)
    rx_fifo_full <= 1'h0;
    rx_char_done <= 1'h1;
    @(posedge aclk) rx_char_done <= 1'h0;
    repeat (3) @(posedge aclk);
    `CHK(push_cnt, 1)
    wr(ADDR_EFR, 8'h50, rs);
    for (i = 0; i < 4; i++)
    begin
      wr(ADDR_MCR, i[1] ? 8'h04 : 8'h00, rs);
      want <= i[0] ? 5'h17 : 5'h1b;
      repeat (10) @(posedge aclk);
      `CHK(tx_stop, 1'(i[1] == i[0]))
    end
    wr(ADDR_EFR, 8'h10, rs);
    wr(ADDR_TXCTL, 8'h01, rs);
    thr_cnt = 0;
    wr(ADDR_MCR, 8'h08, rs);
    // holding write is the very next access.
    wr(ADDR_THR, 8'ha5, rs);
    repeat (4) @(posedge aclk);
    `CHK(imm_valid, 1'h0)
    sw_flow_pending <= 1'h1;
    wr(ADDR_TXCTL, 8'h00, rs);
    repeat (3) @(posedge aclk);
    `CHK(imm_valid, 1'h0)
    sw_flow_pending <= 1'h0;
    repeat (3) @(posedge aclk);
    `CHK({imm_valid, imm_data}, 9'h1a5)
    `CHK(thr_cnt, 0)
    rdr(ADDR_MCR, rd, rs);
    `CHK(rd[3], 1'h0)
    imm_taken <= 1'h1;
    @(posedge aclk) imm_taken <= 1'h0;
    repeat (2) @(posedge aclk);
    `CHK(imm_valid, 1'h0)
    wr(ADDR_THR, 8'h3c, rs);
    repeat (3) @(posedge aclk);
    `CHK(thr_cnt, 1)
    `CHK(thr_data, 8'h3c)
    wr(ADDR_MCR, 8'h20, rs);
    rx_char_done <= 1'h1;
    @(posedge aclk) rx_char_done <= 1'h0;
    @(posedge aclk);
    `CHK(xon_resume, 1'h1)
    want <= 5'h0f;
    repeat (8) @(posedge aclk);
    `CHK(rx_to_core, 1'h0)
    rx_break_det <= 1'h1;
    @(posedge aclk) rx_break_det <= 1'h0;
    @(posedge aclk);
    `CHK(brk_load, 1'h1)
    rdr(ADDR_LSR, rd, rs);
    `CHK(rd[4], 1'h1)
    want <= 5'h1f;
    repeat (8) @(posedge aclk);
    rdr(ADDR_LSR, rd, rs);
    `CHK(rd[4], 1'h0)
    wr(8'h3c, 8'h01, rs);
    `CHK(rs, RESP_SLVERR)
    wr(ADDR_LSR, 8'h01, rs);
    `CHK(rs, RESP_SLVERR)
    rdr(8'h3c, rd, rs);
    `CHK({rs, rd}, {RESP_SLVERR, 8'h00})
    complete_run();
  end
endmodule : uart_modem_line_status_tb_top
